// [rtd_pkg.sv]
// Constants for the reference and touch-detect configuration block.
// Assumes a 10 MHz core clock and a register port already decoded from the serial link.
package rtd_pkg;

	// Register port, timer counter and result register geometry.
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned CNT_W  = 15;
	localparam int unsigned RES_N  = 16;
	localparam int unsigned RES_W  = 4;

	// Page numbers.
	localparam logic PAGE_DATA = 1'b0;
	localparam logic PAGE_CTRL = 1'b1;

	// Control page addresses.
	localparam logic [ADDR_W-1:0] ADDR_KP_CTRL  = 6'h01;
	localparam logic [ADDR_W-1:0] ADDR_DAC_CTRL = 6'h02;
	localparam logic [ADDR_W-1:0] ADDR_SRC_CTRL = 6'h03;
	localparam logic [ADDR_W-1:0] ADDR_TD_CFG   = 6'h05;
	localparam logic [ADDR_W-1:0] ADDR_KP_MASK  = 6'h10;

	// Field positions of source_control.
	localparam int unsigned SRC_VOLT_BIT  = 0;
	localparam int unsigned SRC_SLEEP_BIT = 1;
	localparam int unsigned SRC_DL_LO_BIT = 2;
	localparam int unsigned SRC_DL_HI_BIT = 3;
	localparam int unsigned SRC_INT_BIT   = 4;
	localparam int unsigned SRC_W         = 5;

	// Field positions of touch_detect_config.
	localparam int unsigned TD_WAIT_LSB = 0;
	localparam int unsigned TD_PRE_LSB  = 3;
	localparam int unsigned TD_PEND_BIT = 6;

	// Field positions of dac_power_control and the keypad registers.
	localparam int unsigned DAC_SLEEP_BIT = 15;
	localparam int unsigned KP_DB_LSB     = 11;
	localparam int unsigned KP_STOP_BIT   = 14;
	localparam int unsigned KP_STAT_BIT   = 15;

	// Values after reset and fixed read-back values.
	localparam logic [SRC_W-1:0]  SRC_RST      = 5'h02;
	localparam logic [2:0]        TD_PRE_RST   = 3'h0;
	localparam logic [2:0]        TD_WAIT_RST  = 3'h0;
	localparam logic              DAC_SLP_RST  = 1'b0;
	localparam logic [2:0]        KP_DB_RST    = 3'h0;
	localparam logic [DATA_W-1:0] KP_MASK_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] RD_RESERVED  = 16'hFFFF;
	localparam logic [DATA_W-1:0] RD_ZERO      = 16'h0000;

	// Clock period and time tables, in nanoseconds.
	localparam int unsigned CLK_NS = 100;
	typedef int unsigned rtd_tab4_t [4];
	typedef int unsigned rtd_tab8_t [8];
	localparam rtd_tab4_t SETTLE_NS = '{0, 100_000, 500_000, 1_000_000};
	localparam rtd_tab8_t PRE_NS    = '{20_000, 84_000, 276_000, 340_000,
		1_044_000, 1_108_000, 1_300_000, 1_364_000};
	localparam rtd_tab8_t WAIT_NS   = '{32_000, 96_000, 544_000, 608_000,
		2_080_000, 2_144_000, 2_592_000, 2_656_000};

	// Least times round up to whole clock cycles.
	function automatic int unsigned rtd_cyc(input int unsigned ns);
		return (ns + CLK_NS - 1) / CLK_NS;
	endfunction : rtd_cyc

	localparam rtd_tab4_t SETTLE_CYC = '{rtd_cyc(SETTLE_NS[0]), rtd_cyc(SETTLE_NS[1]),
		rtd_cyc(SETTLE_NS[2]), rtd_cyc(SETTLE_NS[3])};
	localparam rtd_tab8_t PRE_CYC = '{rtd_cyc(PRE_NS[0]), rtd_cyc(PRE_NS[1]),
		rtd_cyc(PRE_NS[2]), rtd_cyc(PRE_NS[3]), rtd_cyc(PRE_NS[4]),
		rtd_cyc(PRE_NS[5]), rtd_cyc(PRE_NS[6]), rtd_cyc(PRE_NS[7])};
	localparam rtd_tab8_t WAIT_CYC = '{rtd_cyc(WAIT_NS[0]), rtd_cyc(WAIT_NS[1]),
		rtd_cyc(WAIT_NS[2]), rtd_cyc(WAIT_NS[3]), rtd_cyc(WAIT_NS[4]),
		rtd_cyc(WAIT_NS[5]), rtd_cyc(WAIT_NS[6]), rtd_cyc(WAIT_NS[7])};

endpackage : rtd_pkg

// [rtd_if.sv]
// Interfaces joining the configuration block to its timer and result tracker.
// Assumes all parties share one clock.
`timescale 1ns/1ps
`default_nettype none

interface rtd_timer_if;
	import rtd_pkg::*;
	logic             start;
	logic [CNT_W-1:0] count;
	logic             busy;
	logic             done;
	modport ctl (output start, output count, input busy, input done);
	modport tmr (input start, input count, output busy, output done);
endinterface : rtd_timer_if

interface rtd_result_if;
	import rtd_pkg::*;
	logic             conv_done;
	logic [RES_N-1:0] update;
	logic             read;
	logic [RES_W-1:0] read_idx;
	logic             pin_n;
	modport ctl (output conv_done, output update, output read, output read_idx, input pin_n);
	modport trk (input conv_done, input update, input read, input read_idx, output pin_n);
endinterface : rtd_result_if

`default_nettype wire

// [rtd_timer.sv]
// Down counter that reports the end of a loaded number of cycles.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module rtd_timer
	import rtd_pkg::*;
(
	// Clock and reset.
	input  wire logic mclk_i,
	input  wire logic reset_i,
	// Control side.
	rtd_timer_if.tmr  t
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;

	// A start reloads the counter, otherwise it runs down to zero.
	always_comb begin
		cnt_nxt = cnt_r;
		if (t.start) begin
			cnt_nxt = t.count;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - CNT_W'(1);
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign t.busy = (cnt_r != '0);
	assign t.done = t.start ? (t.count == '0) : (cnt_r == CNT_W'(1));

endmodule : rtd_timer

`default_nettype wire

// [rtd_result_track.sv]
// Tracks which result registers hold unread data and drives the pending flag.
// Assumes conversion and read events come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module rtd_result_track
	import rtd_pkg::*;
(
	// Clock and reset.
	input  wire logic  mclk_i,
	input  wire logic  reset_i,
	// Event side.
	rtd_result_if.trk  r
);
	logic [RES_N-1:0] pend_r;
	logic [RES_N-1:0] pend_nxt;
	logic             pin_n_r;
	logic             pin_n_nxt;
	logic [RES_N-1:0] clr;

	// A fresh result wins over a read of the same register in the same cycle.
	always_comb begin
		clr       = '0;
		if (r.read) begin
			clr[r.read_idx] = 1'b1;
		end
		pend_nxt  = pend_r & ~clr;
		if (r.conv_done) begin
			pend_nxt = pend_nxt | r.update;
		end
		pin_n_nxt = ~(|pend_nxt);
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			pend_r  <= '0;
			pin_n_r <= 1'b1;
		end else begin
			pend_r  <= pend_nxt;
			pin_n_r <= pin_n_nxt;
		end
	end

	assign r.pin_n = pin_n_r;

endmodule : rtd_result_track

`default_nettype wire

// [rtd_config.sv]
// Reference and touch-detect configuration registers with their timing logic.
// Assumes a serial front end on mclk_i that presents decoded register accesses.
//
// What this block does
// (R1) Source-select bit 4 picks the on-chip source when 1 and the external one when 0, reset 0.
// (R2) After the on-chip source powers up, measurements wait 0, 100, 500 or 1000 us by the delay bits.
// (R3) The two settle-delay bits reset to 00, so no extra delay applies after reset.
// (R4) Sleep bit 1 powers the on-chip source down between conversions when 1, keeps it on when 0, reset 1.
// (R5) With the external source selected the on-chip source stays off whatever the sleep bit holds.
// (R6) Voltage bit 0 selects 1.25 V when 0 and 2.5 V when 1, reset 0.
// (R7) Bits 4 to 0 of the source register read back exactly what was written.
// (R8) A completed conversion drives the pending pin low and clears status bit 6.
// (R9) Pin and bit stay low until the host has read every updated result, then return high.
// (R10) Panel precharge before touch sensing lasts the time chosen by bits 5 to 3.
// (R11) In pen-interrupt mode the wait between axis conversions is the time chosen by bits 2 to 0.
// (R12) The keypad is governed by a control register and a mask register whose set bits hide keys.
// (R13) D/A sleep bit 15 powers the D/A converter down when 1 and keeps it running when 0.
// (R14) Writes to unused bit positions of these registers have no effect.
`timescale 1ns/1ps
`default_nettype none

module rtd_config
	import rtd_pkg::*;
#(
	parameter rtd_pkg::rtd_tab4_t SETTLE_CYCLES  = rtd_pkg::SETTLE_CYC,
	parameter rtd_pkg::rtd_tab8_t PRECHG_CYCLES  = rtd_pkg::PRE_CYC,
	parameter rtd_pkg::rtd_tab8_t WAIT_CYCLES    = rtd_pkg::WAIT_CYC
)
(
	// Clock and reset.
	input  wire logic                        mclk_i,
	input  wire logic                        reset_i,
	// Register port from the serial front end.
	input  wire logic                        reg_wr_i,
	input  wire logic                        reg_rd_i,
	input  wire logic                        reg_page_i,
	input  wire logic [rtd_pkg::ADDR_W-1:0]  reg_addr_i,
	input  wire logic [rtd_pkg::DATA_W-1:0]  reg_wdata_i,
	output logic      [rtd_pkg::DATA_W-1:0]  reg_rdata_o,
	output logic                             reg_rvalid_o,
	// Converter handshakes.
	input  wire logic                        conv_request_i,
	input  wire logic                        conv_active_i,
	input  wire logic                        conv_done_i,
	input  wire logic [rtd_pkg::RES_N-1:0]   conv_update_i,
	output logic                             result_pending_pin_n_o,
	// Reference control.
	output logic                             ref_internal_o,
	output logic                             ref_voltage_hi_o,
	output logic                             ref_power_on_o,
	output logic                             ref_settled_o,
	// Touch detect timing.
	input  wire logic                        pen_touch_irq_mode_i,
	input  wire logic                        precharge_start_i,
	output logic                             precharge_busy_o,
	output logic                             precharge_done_o,
	input  wire logic                        touch_wait_start_i,
	output logic                             touch_wait_busy_o,
	output logic                             touch_wait_done_o,
	// Keypad scanner.
	input  wire logic                        kp_pressed_i,
	input  wire logic                        kp_scan_done_i,
	output logic      [2:0]                  kp_debounce_sel_o,
	output logic      [rtd_pkg::DATA_W-1:0]  kp_mask_o,
	output logic                             kp_stop_o,
	// D/A converter.
	output logic                             dac_sleep_o
);
	import rtd_pkg::*;

	// Register state.
	logic [SRC_W-1:0]  src_r;
	logic [SRC_W-1:0]  src_nxt;
	logic [2:0]        pre_r;
	logic [2:0]        pre_nxt;
	logic [2:0]        wait_r;
	logic [2:0]        wait_nxt;
	logic              dac_sleep_r;
	logic              dac_sleep_nxt;
	logic [2:0]        kp_db_r;
	logic [2:0]        kp_db_nxt;
	logic [DATA_W-1:0] kp_mask_r;
	logic [DATA_W-1:0] kp_mask_nxt;
	logic              kp_stop_r;
	logic              kp_stop_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic              rvalid_r;
	logic              rvalid_nxt;

	// Reference sequencing state.
	logic              pwr_r;
	logic              pwr_nxt;
	logic              settled_r;
	logic              settled_nxt;

	logic              ctl_wr;
	logic [1:0]        dl_sel;
	logic              int_sel;
	logic              sleep_sel;

	rtd_timer_if  settle_t ();
	rtd_timer_if  pre_t ();
	rtd_timer_if  wait_t ();
	rtd_result_if res ();

	assign ctl_wr    = reg_wr_i && (reg_page_i == PAGE_CTRL);
	assign int_sel   = src_r[SRC_INT_BIT];
	assign sleep_sel = src_r[SRC_SLEEP_BIT];
	assign dl_sel    = {src_r[SRC_DL_HI_BIT], src_r[SRC_DL_LO_BIT]};

	// Register writes; only the defined fields are stored.
	always_comb begin
		src_nxt       = src_r;
		pre_nxt       = pre_r;
		wait_nxt      = wait_r;
		dac_sleep_nxt = dac_sleep_r;
		kp_db_nxt     = kp_db_r;
		kp_mask_nxt   = kp_mask_r;
		kp_stop_nxt   = 1'b0;
		if (ctl_wr) begin
			if (reg_addr_i == ADDR_SRC_CTRL) begin
				src_nxt = reg_wdata_i[SRC_W-1:0]; // R1 R6 R7 R14
			end else if (reg_addr_i == ADDR_TD_CFG) begin
				pre_nxt  = reg_wdata_i[TD_PRE_LSB +: 3]; // R10 R14
				wait_nxt = reg_wdata_i[TD_WAIT_LSB +: 3]; // R11
			end else if (reg_addr_i == ADDR_DAC_CTRL) begin
				dac_sleep_nxt = reg_wdata_i[DAC_SLEEP_BIT]; // R13 R14
			end else if (reg_addr_i == ADDR_KP_CTRL) begin
				kp_db_nxt   = reg_wdata_i[KP_DB_LSB +: 3]; // R12
				kp_stop_nxt = reg_wdata_i[KP_STOP_BIT]; // R12
			end else if (reg_addr_i == ADDR_KP_MASK) begin
				kp_mask_nxt = reg_wdata_i; // R12
			end
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			src_r       <= SRC_RST; // R1 R3 R4 R6
			pre_r       <= TD_PRE_RST;
			wait_r      <= TD_WAIT_RST;
			dac_sleep_r <= DAC_SLP_RST;
			kp_db_r     <= KP_DB_RST;
			kp_mask_r   <= KP_MASK_RST;
			kp_stop_r   <= 1'b0;
		end else begin
			src_r       <= src_nxt;
			pre_r       <= pre_nxt;
			wait_r      <= wait_nxt;
			dac_sleep_r <= dac_sleep_nxt;
			kp_db_r     <= kp_db_nxt;
			kp_mask_r   <= kp_mask_nxt;
			kp_stop_r   <= kp_stop_nxt;
		end
	end

	// Read data is registered one cycle after the request; unmapped control addresses read ones.
	always_comb begin
		rdata_nxt  = rdata_r;
		rvalid_nxt = reg_rd_i;
		if (reg_rd_i) begin
			rdata_nxt = RD_ZERO;
			if (reg_page_i == PAGE_DATA) begin
				rdata_nxt = RD_ZERO;
			end else if (reg_addr_i == ADDR_SRC_CTRL) begin
				rdata_nxt[SRC_W-1:0] = src_r; // R7
			end else if (reg_addr_i == ADDR_TD_CFG) begin
				rdata_nxt[TD_PEND_BIT]         = res.pin_n; // R8 R9
				rdata_nxt[TD_PRE_LSB +: 3]     = pre_r;
				rdata_nxt[TD_WAIT_LSB +: 3]    = wait_r;
			end else if (reg_addr_i == ADDR_DAC_CTRL) begin
				rdata_nxt[DAC_SLEEP_BIT] = dac_sleep_r;
			end else if (reg_addr_i == ADDR_KP_CTRL) begin
				rdata_nxt[KP_STAT_BIT]     = kp_pressed_i;
				rdata_nxt[KP_STOP_BIT]     = kp_scan_done_i;
				rdata_nxt[KP_DB_LSB +: 3]  = kp_db_r;
			end else if (reg_addr_i == ADDR_KP_MASK) begin
				rdata_nxt = kp_mask_r;
			end else begin
				rdata_nxt = RD_RESERVED;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_r  <= RD_ZERO;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// Reference power: off when external, always on when not sleeping, else only around conversions.
	always_comb begin
		pwr_nxt = int_sel && (!sleep_sel || conv_request_i || conv_active_i); // R4 R5
		settled_nxt = settled_r;
		if (!pwr_nxt) begin
			settled_nxt = 1'b0;
		end else if (settle_t.done) begin
			settled_nxt = 1'b1; // R2
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			pwr_r     <= 1'b0;
			settled_r <= 1'b0;
		end else begin
			pwr_r     <= pwr_nxt;
			settled_r <= settled_nxt;
		end
	end

	// The settle count starts on the cycle the source turns on.
	assign settle_t.start = pwr_nxt && !pwr_r; // R2
	assign settle_t.count = CNT_W'(SETTLE_CYCLES[dl_sel]); // R2 R3

	rtd_timer u_settle (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.t       (settle_t)
	);

	// Touch precharge and pen-mode sense waits.
	assign pre_t.start  = precharge_start_i;
	assign pre_t.count  = CNT_W'(PRECHG_CYCLES[pre_r]); // R10
	assign wait_t.start = touch_wait_start_i && pen_touch_irq_mode_i; // R11
	assign wait_t.count = CNT_W'(WAIT_CYCLES[wait_r]); // R11

	rtd_timer u_precharge (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.t       (pre_t)
	);

	rtd_timer u_touch_wait (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.t       (wait_t)
	);

	// Result tracking; data-page reads retire pending results.
	assign res.conv_done = conv_done_i; // R8
	assign res.update    = conv_update_i;
	assign res.read      = reg_rd_i && (reg_page_i == PAGE_DATA); // R9
	assign res.read_idx  = reg_addr_i[RES_W-1:0];

	rtd_result_track u_result (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.r       (res)
	);

	// Outputs.
	assign reg_rdata_o            = rdata_r;
	assign reg_rvalid_o           = rvalid_r;
	assign result_pending_pin_n_o = res.pin_n; // R8 R9
	assign ref_internal_o         = int_sel; // R1
	assign ref_voltage_hi_o       = src_r[SRC_VOLT_BIT]; // R6
	assign ref_power_on_o         = pwr_r; // R4 R5
	assign ref_settled_o          = !int_sel || settled_r; // R2
	assign precharge_busy_o       = pre_t.busy;
	assign precharge_done_o       = pre_t.done;
	assign touch_wait_busy_o      = wait_t.busy;
	assign touch_wait_done_o      = wait_t.done;
	assign kp_debounce_sel_o      = kp_db_r; // R12
	assign kp_mask_o              = kp_mask_r; // R12
	assign kp_stop_o              = kp_stop_r;
	assign dac_sleep_o            = dac_sleep_r; // R13

endmodule : rtd_config

`default_nettype wire

// [rtd_config_asserts.sv]
// Checker for the port behaviour of the configuration block.
// Assumes it is bound onto rtd_config, which has one clock and an asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module rtd_config_asserts
	import rtd_pkg::*;
(
	input  wire logic                       mclk_i,
	input  wire logic                       reset_i,
	input  wire logic                       reg_wr_i,
	input  wire logic                       reg_rd_i,
	input  wire logic                       reg_page_i,
	input  wire logic [rtd_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic [rtd_pkg::DATA_W-1:0] reg_wdata_i,
	input  wire logic                       reg_rvalid_o,
	input  wire logic                       conv_active_i,
	input  wire logic                       conv_done_i,
	input  wire logic [rtd_pkg::RES_N-1:0]  conv_update_i,
	input  wire logic                       result_pending_pin_n_o,
	input  wire logic                       ref_internal_o,
	input  wire logic                       ref_voltage_hi_o,
	input  wire logic                       ref_power_on_o,
	input  wire logic                       ref_settled_o,
	input  wire logic                       dac_sleep_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	a_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("stray read valid");
	a_done_sets_pend: assert property (conv_done_i && conv_update_i != '0 |=> !result_pending_pin_n_o)
		else $error("pending not raised");
	a_pend_stays_idle: assert property (result_pending_pin_n_o && !conv_done_i |=> result_pending_pin_n_o)
		else $error("pending raised without conversion");
	a_pend_holds_low: assert property (!result_pending_pin_n_o && !reg_rd_i |=> !result_pending_pin_n_o)
		else $error("pending cleared without read");
	a_ext_power_off: assert property (!ref_internal_o && !$past(ref_internal_o) |-> !ref_power_on_o)
		else $error("on-chip source powered with external selected");
	a_ext_settled: assert property (!ref_internal_o && !$past(ref_internal_o) |-> ref_settled_o)
		else $error("external source not ready");
	a_active_powers: assert property (ref_internal_o && conv_active_i ##1 ref_internal_o |-> ref_power_on_o)
		else $error("source off during conversion");
	a_settle_bound: assert property ($rose(ref_power_on_o) ##1 ref_power_on_o [*8] |-> ref_settled_o)
		else $error("source never settled");
	a_dac_write: assert property (reg_wr_i && reg_page_i && reg_addr_i == ADDR_DAC_CTRL |=>
		dac_sleep_o == $past(reg_wdata_i[15])) else $error("dac sleep not written");
	a_src_write: assert property (reg_wr_i && reg_page_i && reg_addr_i == ADDR_SRC_CTRL |=>
		ref_voltage_hi_o == $past(reg_wdata_i[0]) && ref_internal_o == $past(reg_wdata_i[4]))
		else $error("source fields not written");
	c_pend: cover property (conv_done_i ##1 !result_pending_pin_n_o);
	c_power: cover property ($rose(ref_power_on_o));
	c_dac: cover property ($rose(dac_sleep_o));
endmodule : rtd_config_asserts
bind rtd_config rtd_config_asserts u_chk (.*);
`default_nettype wire

// [rtd_host.sv]
// Host model that issues single-word accesses on the register port.
// Assumes the block answers a read one cycle after taking it.
`timescale 1ns/1ps
`default_nettype none
module rtd_host
	import rtd_pkg::*;
(
	input  wire logic                       mclk_i,
	output logic                            reg_wr_o,
	output logic                            reg_rd_o,
	output logic                            reg_page_o,
	output logic      [rtd_pkg::ADDR_W-1:0] reg_addr_o,
	output logic      [rtd_pkg::DATA_W-1:0] reg_wdata_o,
	input  wire logic [rtd_pkg::DATA_W-1:0] reg_rdata_i,
	input  wire logic                       reg_rvalid_i
);
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_page_o = 1'b0;
		reg_addr_o = '0;
		reg_wdata_o = '0;
	end
	// Idle address and data are inverted so stale values are never trusted.
	task automatic acc(input logic w, input logic p, input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		reg_page_o <= p;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= w;
		reg_rd_o <= !w;
		@(posedge mclk_i);
		reg_wr_o <= 1'b0;
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
		#1;
	endtask : acc
	task automatic rd(input logic p, input logic [5:0] a, output logic [15:0] d, output logic v);
		acc(1'b0, p, a, 16'h0000);
		d = reg_rdata_i;
		v = reg_rvalid_i;
	endtask : rd
endmodule : rtd_host
`default_nettype wire

// [rtd_config_tb.sv]
// Self-checking testbench for the configuration block.
// Assumes shortened timer tables and a host model on the register port.
`timescale 1ns/1ps
`default_nettype none
module rtd_config_tb;
	import rtd_pkg::*;
	localparam rtd_tab4_t ST = '{0, 3, 5, 6};
	localparam rtd_tab8_t PC = '{2, 3, 4, 5, 6, 7, 8, 9};
	localparam rtd_tab8_t WC = '{3, 4, 5, 6, 7, 8, 9, 10};
	logic mclk_i = 1'b0, reset_i = 1'b1, reg_wr_i, reg_rd_i, reg_page_i, reg_rvalid_o;
	logic [5:0] reg_addr_i;
	logic [15:0] reg_wdata_i, reg_rdata_o, kp_mask_o, conv_update_i = 16'h0000;
	logic conv_request_i = 1'b0, conv_active_i = 1'b0, conv_done_i = 1'b0;
	logic pen_touch_irq_mode_i = 1'b0, precharge_start_i = 1'b0, touch_wait_start_i = 1'b0;
	logic kp_pressed_i = 1'b0, kp_scan_done_i = 1'b0;
	logic result_pending_pin_n_o, ref_internal_o, ref_voltage_hi_o, ref_power_on_o;
	logic ref_settled_o, precharge_busy_o, precharge_done_o, touch_wait_busy_o;
	logic touch_wait_done_o, kp_stop_o, dac_sleep_o;
	logic [2:0] kp_debounce_sel_o;
	int num_errors = 0;
	int tests_run = 0;
	always #50 mclk_i = ~mclk_i;
	rtd_config #(.SETTLE_CYCLES(ST), .PRECHG_CYCLES(PC), .WAIT_CYCLES(WC)) dut (.*);
	rtd_host host (.mclk_i(mclk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
		.reg_page_o(reg_page_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
		.reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rdchk(input logic p, input logic [5:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic v;
		host.rd(p, a, d, v);
		chk({15'h0000, v}, 16'h0001);
		chk(d, e);
	endtask : rdchk
	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : wait_n
	task automatic tmr(input bit w, input int n);
		int k;
		@(posedge mclk_i);
		if (w) touch_wait_start_i <= 1'b1;
		else precharge_start_i <= 1'b1;
		wait_n(1);
		touch_wait_start_i <= 1'b0;
		precharge_start_i <= 1'b0;
		k = 1;
		while ((w ? touch_wait_done_o : precharge_done_o) !== 1'b1 && k < 40) begin
			wait_n(1);
			k++;
		end
		chk(16'(k), 16'(n));
		chk({15'h0000, w ? touch_wait_busy_o : precharge_busy_o}, 16'h0001);
	endtask : tmr
	task automatic s_reset();
		rdchk(1'b1, ADDR_SRC_CTRL, 16'h0002);
		rdchk(1'b1, ADDR_TD_CFG, 16'h0040);
		rdchk(1'b1, ADDR_DAC_CTRL, 16'h0000);
		chk({15'h0000, ref_settled_o}, 16'h0001);
	endtask : s_reset
	task automatic s_src();
		logic [15:0] v [5] = '{16'hFFFF, 16'h0000, 16'h0015, 16'h000A, 16'hFFE0};
		for (int i = 0; i < 5; i++) begin
			host.acc(1'b1, 1'b1, ADDR_SRC_CTRL, v[i]);
			chk({14'h0000, ref_internal_o, ref_voltage_hi_o}, {14'h0000, v[i][4], v[i][0]});
			rdchk(1'b1, ADDR_SRC_CTRL, v[i] & 16'h001F);
		end
	endtask : s_src
	task automatic s_power();
		host.acc(1'b1, 1'b1, ADDR_SRC_CTRL, 16'h001E);
		wait_n(3);
		chk({15'h0000, ref_power_on_o}, 16'h0000);
		conv_request_i <= 1'b1;
		conv_active_i <= 1'b1;
		wait_n(12);
		chk({14'h0000, ref_power_on_o, ref_settled_o}, 16'h0003);
		conv_request_i <= 1'b0;
		conv_active_i <= 1'b0;
		wait_n(3);
		chk({15'h0000, ref_power_on_o}, 16'h0000);
		host.acc(1'b1, 1'b1, ADDR_SRC_CTRL, 16'h0014);
		wait_n(3);
		chk({15'h0000, ref_power_on_o}, 16'h0001);
		host.acc(1'b1, 1'b1, ADDR_SRC_CTRL, 16'h0000);
		conv_request_i <= 1'b1;
		wait_n(3);
		chk({14'h0000, ref_power_on_o, ref_settled_o}, 16'h0001);
		conv_request_i <= 1'b0;
		host.acc(1'b1, 1'b1, ADDR_SRC_CTRL, 16'h0010);
		wait_n(1);
		chk({14'h0000, ref_power_on_o, ref_settled_o}, 16'h0003);
	endtask : s_power
	task automatic s_results();
		@(posedge mclk_i);
		conv_done_i <= 1'b1;
		conv_update_i <= 16'h0003;
		wait_n(1);
		conv_done_i <= 1'b0;
		conv_update_i <= 16'hFFFC;
		chk({15'h0000, result_pending_pin_n_o}, 16'h0000);
		rdchk(1'b1, ADDR_TD_CFG, 16'h0000);
		rdchk(1'b0, 6'h00, 16'h0000);
		chk({15'h0000, result_pending_pin_n_o}, 16'h0000);
		rdchk(1'b0, 6'h01, 16'h0000);
		chk({15'h0000, result_pending_pin_n_o}, 16'h0001);
		rdchk(1'b1, ADDR_TD_CFG, 16'h0040);
	endtask : s_results
	task automatic s_timers();
		logic [15:0] c;
		pen_touch_irq_mode_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			c = {10'h000, i[2:0], 3'(7 - i)};
			host.acc(1'b1, 1'b1, ADDR_TD_CFG, c);
			rdchk(1'b1, ADDR_TD_CFG, c | 16'h0040);
			tmr(1'b0, PC[i]);
			tmr(1'b1, WC[7 - i]);
		end
		pen_touch_irq_mode_i <= 1'b0;
		@(posedge mclk_i);
		touch_wait_start_i <= 1'b1;
		wait_n(1);
		touch_wait_start_i <= 1'b0;
		wait_n(2);
		chk({15'h0000, touch_wait_busy_o | touch_wait_done_o}, 16'h0000);
	endtask : s_timers
	task automatic s_dac_kp();
		host.acc(1'b1, 1'b1, ADDR_DAC_CTRL, 16'h8000);
		chk({15'h0000, dac_sleep_o}, 16'h0001);
		rdchk(1'b1, ADDR_DAC_CTRL, 16'h8000);
		host.acc(1'b1, 1'b1, ADDR_DAC_CTRL, 16'h7FFF);
		rdchk(1'b1, ADDR_DAC_CTRL, 16'h0000);
		host.acc(1'b1, 1'b1, ADDR_KP_MASK, 16'hA5A5);
		chk(kp_mask_o, 16'hA5A5);
		rdchk(1'b1, ADDR_KP_MASK, 16'hA5A5);
		kp_pressed_i <= 1'b1;
		kp_scan_done_i <= 1'b1;
		host.acc(1'b1, 1'b1, ADDR_KP_CTRL, 16'h2800);
		chk({13'h0000, kp_debounce_sel_o}, 16'h0005);
		rdchk(1'b1, ADDR_KP_CTRL, 16'hE800);
		host.acc(1'b1, 1'b1, ADDR_KP_CTRL, 16'h4000);
		chk({15'h0000, kp_stop_o}, 16'h0001);
		rdchk(1'b1, 6'h3F, 16'hFFFF);
	endtask : s_dac_kp
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#1_000_000;
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge mclk_i);
		reset_i <= 1'b0;
		s_reset();
		s_src();
		s_power();
		s_results();
		s_timers();
		s_dac_kp();
		give_verdict();
	end
endmodule : rtd_config_tb
`default_nettype wire
